// ### rtl/irqsf_defines.vh
// Constants for the interrupt and status flag block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef IRQSF_DEFINES_VH
`define IRQSF_DEFINES_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define IRQSF_ADDR_STATUS 8'h0A
`define IRQSF_ADDR_CTRL_LO 8'h0B
`define IRQSF_ADDR_CTRL_HI 8'h1E
// ----------------------------------------
// Status bits
// ----------------------------------------
`define IRQSF_ST_CARRY 0
`define IRQSF_ST_HALF 1
`define IRQSF_ST_ZERO 2
`define IRQSF_ST_WRAP 3
`define IRQSF_ST_SLEEP 4
`define IRQSF_ST_WDOG 5
// ----------------------------------------
// Low control bits
// ----------------------------------------
`define IRQSF_LO_GIE 0
`define IRQSF_LO_PIN_EN 1
`define IRQSF_LO_T0_EN 2
`define IRQSF_LO_T1_EN 3
`define IRQSF_LO_PIN_PEND 4
`define IRQSF_LO_T0_PEND 5
`define IRQSF_LO_T1_PEND 6
// ----------------------------------------
// High control bits
// ----------------------------------------
`define IRQSF_HI_T2_PEND 0
`define IRQSF_HI_T3_PEND 1
`define IRQSF_HI_T2_EN 4
`define IRQSF_HI_T3_EN 5
// ----------------------------------------
// Vectors and source indices
// ----------------------------------------
`define IRQSF_VEC_PIN 8'h04
`define IRQSF_VEC_T0 8'h08
`define IRQSF_VEC_T1 8'h0C
`define IRQSF_VEC_T2 8'h10
`define IRQSF_VEC_T3 8'h14
`define IRQSF_NSRC 5
`define IRQSF_SRC_PIN 0
`define IRQSF_SRC_T0 1
`define IRQSF_SRC_T1 2
`define IRQSF_SRC_T2 3
`define IRQSF_SRC_T3 4
`endif

// ### rtl/irqsf_alu_flags.v
// Arithmetic flag computation for one ALU operation.
// Assumes operands and result come from the core's ALU in the same cycle.
`include "irqsf_defines.vh"

module irqsf_alu_flags
(
    input wire [7:0] op_a_i,
    input wire [7:0] op_b_i,
    input wire carry_in_i,
    input wire is_sub_i,
    output wire [7:0] sum_o,
    output wire carry_o,
    output wire half_o,
    output wire wrap_o
);
    // Subtraction is a + ~b + carry, so carry out means no borrow
    wire [7:0] b_eff;
    wire [4:0] low_sum;
    wire [7:0] low7_sum;
    wire [8:0] full_sum;

    assign b_eff = is_sub_i ? ~op_b_i : op_b_i;
    assign low_sum = {1'b0, op_a_i[3:0]} + {1'b0, b_eff[3:0]}
        + {4'h0, carry_in_i};
    assign low7_sum = {1'b0, op_a_i[6:0]} + {1'b0, b_eff[6:0]}
        + {7'h00, carry_in_i};
    assign full_sum = {1'b0, op_a_i} + {1'b0, b_eff} + {8'h00, carry_in_i};
    assign sum_o = full_sum[7:0];
    assign carry_o = full_sum[8];
    assign half_o = low_sum[4];
    assign wrap_o = low7_sum[7] ^ full_sum[8];
endmodule

// ### rtl/irqsf_core.v
// Interrupt request, enable and vectoring logic with the status flags.
// Assumes one core clock; phase pulse, instruction strobes, timer
// overflows and register accesses are synchronous single-cycle pulses.
`include "irqsf_defines.vh"

module irqsf_core
#(
    parameter PIN_BOTH_EDGES = 1'b1
)
(
    input wire ref_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    // Register access from the core data path
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // ALU result reporting
    input wire alu_arith_i,
    input wire alu_logic_i,
    input wire alu_rotate_i,
    input wire [7:0] alu_op_a_i,
    input wire [7:0] alu_op_b_i,
    input wire alu_is_sub_i,
    input wire alu_use_carry_i,
    input wire [7:0] alu_logic_result_i,
    input wire alu_rot_carry_i,
    // Instruction and power events
    input wire halt_exec_i,
    input wire watchdog_kick_i,
    input wire watchdog_timeout_i,
    input wire isr_exit_restore_i,
    input wire subroutine_exit_i,
    // Sources and sequencing
    input wire ext_irq_pin_i,
    input wire [3:0] timer_overflow_i,
    input wire stack_full_i,
    input wire phase_two_pulse_i,
    output reg irq_ack_o,
    output reg [7:0] irq_vector_o,
    output reg [7:0] status_o
);
    // ----------------------------------------
    // Flag storage
    // ----------------------------------------
    reg carry_flag;
    reg half_carry_flag;
    reg zero_flag;
    reg signed_wrap_flag;
    reg sleep_entered_flag;
    reg watchdog_expired_flag;
    reg global_irq_enable;
    reg pin_irq_enable;
    reg timer0_irq_enable;
    reg timer1_irq_enable;
    reg timer2_irq_enable;
    reg timer3_irq_enable;
    reg pin_irq_pending;
    reg timer0_pending;
    reg timer1_pending;
    reg timer2_pending;
    reg timer3_pending;
    reg pin_last;
    reg pin_seen;
    reg ack_hold;

    wire [7:0] sum;
    wire sum_carry;
    wire sum_half;
    wire sum_wrap;
    wire wr_status;
    wire wr_lo;
    wire wr_hi;
    wire pin_edge;
    wire [4:0] ready;
    wire [4:0] grant;
    wire take;
    wire [7:0] status_word;
    wire [7:0] ctrl_lo_word;
    wire [7:0] ctrl_hi_word;

    // Lowest set index wins; index order is the priority order
    function [4:0] irqsf_pick;
        input [4:0] req;
        begin
            irqsf_pick = req & (~req + 5'h01);
        end
    endfunction

    function [7:0] irqsf_vector;
        input [4:0] g;
        begin
            case (g)
                5'h01: irqsf_vector = `IRQSF_VEC_PIN;
                5'h02: irqsf_vector = `IRQSF_VEC_T0;
                5'h04: irqsf_vector = `IRQSF_VEC_T1;
                5'h08: irqsf_vector = `IRQSF_VEC_T2;
                5'h10: irqsf_vector = `IRQSF_VEC_T3;
                default: irqsf_vector = 8'h00;
            endcase
        end
    endfunction

    irqsf_alu_flags u_alu_flags
    (
        .op_a_i(alu_op_a_i),
        .op_b_i(alu_op_b_i),
        .carry_in_i(alu_use_carry_i ? carry_flag : alu_is_sub_i),
        .is_sub_i(alu_is_sub_i),
        .sum_o(sum),
        .carry_o(sum_carry),
        .half_o(sum_half),
        .wrap_o(sum_wrap)
    );

    // ----------------------------------------
    // Decode and request selection
    // ----------------------------------------
    assign wr_status = reg_wr_i && (reg_addr_i == `IRQSF_ADDR_STATUS);
    assign wr_lo = reg_wr_i && (reg_addr_i == `IRQSF_ADDR_CTRL_LO);
    assign wr_hi = reg_wr_i && (reg_addr_i == `IRQSF_ADDR_CTRL_HI);
    // Falling edge always counts; rising only when both edges are chosen
    assign pin_edge = (pin_seen && pin_last && !ext_irq_pin_i)
        || (pin_seen && PIN_BOTH_EDGES && !pin_last && ext_irq_pin_i);

    // Enables gate servicing only; they never stop flags latching
    assign ready = {timer3_pending & timer3_irq_enable,
                    timer2_pending & timer2_irq_enable,
                    timer1_pending & timer1_irq_enable,
                    timer0_pending & timer0_irq_enable,
                    pin_irq_pending & pin_irq_enable};
    // Stack-full holds the request; it stays pending for a later pulse
    assign take = phase_two_pulse_i && global_irq_enable
        && !stack_full_i && (ready != 5'h00);
    assign grant = take ? irqsf_pick(ready) : 5'h00;

    assign status_word = {2'b00, watchdog_expired_flag, sleep_entered_flag,
        signed_wrap_flag, zero_flag, half_carry_flag, carry_flag};
    assign ctrl_lo_word = {1'b0, timer1_pending, timer0_pending,
        pin_irq_pending, timer1_irq_enable, timer0_irq_enable,
        pin_irq_enable, global_irq_enable};
    assign ctrl_hi_word = {2'b00, timer3_irq_enable, timer2_irq_enable,
        2'b00, timer3_pending, timer2_pending};

    // ----------------------------------------
    // Arithmetic flags
    // ----------------------------------------
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            carry_flag <= 1'b0;
            half_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
            signed_wrap_flag <= 1'b0;
        end
        else if (clk_en_i)
        begin
            // ALU results take precedence over a direct register write
            if (alu_arith_i)
            begin
                carry_flag <= sum_carry;
                half_carry_flag <= sum_half;
                signed_wrap_flag <= sum_wrap;
                zero_flag <= (sum == 8'h00);
            end
            else if (alu_rotate_i)
                carry_flag <= alu_rot_carry_i;
            else if (alu_logic_i)
                zero_flag <= (alu_logic_result_i == 8'h00);
            else if (wr_status)
            begin
                carry_flag <= reg_wdata_i[`IRQSF_ST_CARRY];
                half_carry_flag <= reg_wdata_i[`IRQSF_ST_HALF];
                zero_flag <= reg_wdata_i[`IRQSF_ST_ZERO];
                signed_wrap_flag <= reg_wdata_i[`IRQSF_ST_WRAP];
            end
        end
    end

    // ----------------------------------------
    // Power flags
    // ----------------------------------------
    // Register writes never reach these two bits
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sleep_entered_flag <= 1'b0;
            watchdog_expired_flag <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (halt_exec_i)
                sleep_entered_flag <= 1'b1;
            else if (watchdog_kick_i)
                sleep_entered_flag <= 1'b0;
            if (watchdog_timeout_i)
                watchdog_expired_flag <= 1'b1;
            else if (watchdog_kick_i || halt_exec_i)
                watchdog_expired_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control registers and pending flags
    // ----------------------------------------
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            global_irq_enable <= 1'b0;
            pin_irq_enable <= 1'b0;
            timer0_irq_enable <= 1'b0;
            timer1_irq_enable <= 1'b0;
            timer2_irq_enable <= 1'b0;
            timer3_irq_enable <= 1'b0;
            pin_irq_pending <= 1'b0;
            timer0_pending <= 1'b0;
            timer1_pending <= 1'b0;
            timer2_pending <= 1'b0;
            timer3_pending <= 1'b0;
            pin_last <= 1'b1;
            pin_seen <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pin_last <= ext_irq_pin_i;
            pin_seen <= 1'b1;
            if (wr_lo)
            begin
                global_irq_enable <= reg_wdata_i[`IRQSF_LO_GIE];
                pin_irq_enable <= reg_wdata_i[`IRQSF_LO_PIN_EN];
                timer0_irq_enable <= reg_wdata_i[`IRQSF_LO_T0_EN];
                timer1_irq_enable <= reg_wdata_i[`IRQSF_LO_T1_EN];
                pin_irq_pending <= reg_wdata_i[`IRQSF_LO_PIN_PEND];
                timer0_pending <= reg_wdata_i[`IRQSF_LO_T0_PEND];
                timer1_pending <= reg_wdata_i[`IRQSF_LO_T1_PEND];
            end
            if (wr_hi)
            begin
                timer2_irq_enable <= reg_wdata_i[`IRQSF_HI_T2_EN];
                timer3_irq_enable <= reg_wdata_i[`IRQSF_HI_T3_EN];
                timer2_pending <= reg_wdata_i[`IRQSF_HI_T2_PEND];
                timer3_pending <= reg_wdata_i[`IRQSF_HI_T3_PEND];
            end
            // Global enable: return restores, service clears last
            if (isr_exit_restore_i)
                global_irq_enable <= 1'b1;
            if (take)
                global_irq_enable <= 1'b0;
            // Service clears the granted flag
            if (grant[`IRQSF_SRC_PIN])
                pin_irq_pending <= 1'b0;
            if (grant[`IRQSF_SRC_T0])
                timer0_pending <= 1'b0;
            if (grant[`IRQSF_SRC_T1])
                timer1_pending <= 1'b0;
            if (grant[`IRQSF_SRC_T2])
                timer2_pending <= 1'b0;
            if (grant[`IRQSF_SRC_T3])
                timer3_pending <= 1'b0;
            // New events written last so they win over any clear
            if (pin_edge)
                pin_irq_pending <= 1'b1;
            if (timer_overflow_i[0])
                timer0_pending <= 1'b1;
            if (timer_overflow_i[1])
                timer1_pending <= 1'b1;
            if (timer_overflow_i[2])
                timer2_pending <= 1'b1;
            if (timer_overflow_i[3])
                timer3_pending <= 1'b1;
        end
    end

    // ----------------------------------------
    // Acknowledge to the sequencer
    // ----------------------------------------
    // Sequencer pushes only its program counter on ack; nothing here
    // saves status, and plain return has no effect on this block.
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_ack_o <= 1'b0;
            irq_vector_o <= 8'h00;
            ack_hold <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (take)
            begin
                irq_ack_o <= 1'b1;
                irq_vector_o <= irqsf_vector(grant);
                ack_hold <= 1'b1;
            end
            else if (phase_two_pulse_i && ack_hold)
            begin
                irq_ack_o <= 1'b0;
                irq_vector_o <= 8'h00;
                ack_hold <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read data and status mirror
    // ----------------------------------------
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            reg_rdata_o <= 8'h00;
            status_o <= 8'h00;
        end
        else if (clk_en_i)
        begin
            status_o <= status_word;
            case (reg_addr_i)
                `IRQSF_ADDR_STATUS: reg_rdata_o <= status_word;
                `IRQSF_ADDR_CTRL_LO: reg_rdata_o <= ctrl_lo_word;
                `IRQSF_ADDR_CTRL_HI: reg_rdata_o <= ctrl_hi_word;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ### tb/irqsf_core_asserts.sv
// Port-level checks for the interrupt and status flag block.
// Assumes one clock domain; bound onto irqsf_core below.
module irqsf_core_asserts
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic phase_two_pulse_i,
    input wire logic stack_full_i,
    input wire logic halt_exec_i,
    input wire logic watchdog_kick_i,
    input wire logic watchdog_timeout_i,
    input wire logic irq_ack_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic [7:0] status_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // --------------------------------
    // Acknowledge and vector
    // --------------------------------
    ack_vec_ok_a: assert property (irq_ack_o |-> irq_vector_o inside
        {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}) else $error("bad vector");
    idle_vec_zero_a: assert property (!irq_ack_o |-> irq_vector_o == 8'h00)
        else $error("vector without ack");
    take_on_phase_a: assert property ($rose(irq_ack_o) |->
        $past(phase_two_pulse_i && clk_en_i)) else $error("take off phase");
    full_blocks_a: assert property ($rose(irq_ack_o) |-> !$past(stack_full_i))
        else $error("take with stack full");
    ack_hold_a: assert property (irq_ack_o && !phase_two_pulse_i && clk_en_i
        |=> irq_ack_o && $stable(irq_vector_o)) else $error("ack dropped");
    ack_drop_a: assert property (irq_ack_o && phase_two_pulse_i && clk_en_i
        && stack_full_i |=> !irq_ack_o) else $error("ack held while full");
    // --------------------------------
    // Power flags, seen two edges later; unused top status bits
    // --------------------------------
    sleep_cause_a: assert property ($changed(status_o[4]) |->
        $past(halt_exec_i || watchdog_kick_i, 2)) else $error("bit4 moved");
    wdog_cause_a: assert property ($changed(status_o[5]) |-> $past(
        watchdog_timeout_i || watchdog_kick_i || halt_exec_i, 2))
        else $error("bit5 moved");
    wdog_set_a: assert property (watchdog_timeout_i && clk_en_i |->
        ##2 status_o[5]) else $error("timeout not flagged");
    halt_set_a: assert property (halt_exec_i && clk_en_i && !watchdog_kick_i
        && !watchdog_timeout_i |-> ##2 status_o[5:4] == 2'h1)
        else $error("halt flags wrong");
    top_zero_a: assert property (status_o[7:6] == 2'h0)
        else $error("unused status bits set");
endmodule

bind irqsf_core irqsf_core_asserts chk_u (.*);

// ### tb/irqsf_seq_model.sv
// Core sequencer stand-in: phase pulse and a small return stack.
// Assumes pops come from the two return strobes of the bench.
module irqsf_seq_model
#(
    parameter int PERIOD = 4,
    parameter int DEPTH = 2
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ack_i,
    input wire logic [7:0] vec_i,
    input wire logic pop_i,
    output logic phase_o,
    output logic full_o
);
    int div;
    int cnt;
    logic pa;
    logic [7:0] pv;
    logic take;
    // A restart with a new vector is a fresh push
    assign take = ack_i && (!pa || vec_i != pv);
    assign full_o = cnt >= DEPTH;
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            div <= 0;
            cnt <= 0;
            phase_o <= 1'h0;
            pa <= 1'h0;
            pv <= 8'h00;
        end
        else
        begin
            div <= (div == PERIOD - 1) ? 0 : div + 1;
            phase_o <= div == PERIOD - 1;
            pa <= ack_i;
            pv <= vec_i;
            cnt <= cnt + int'(take) - int'(pop_i && cnt != 0);
        end
    end
endmodule

// ### tb/irqsf_core_tb.sv
// Self-checking bench for the interrupt and status flag block.
// Assumes irqsf_core, its checker and the sequencer model.
module irqsf_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'h0, rst_b_i = 1'h0, clk_en_i = 1'h1;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic [7:0] alu_op_a_i = 8'h00, alu_op_b_i = 8'h00;
    logic [7:0] alu_logic_result_i = 8'h00;
    logic reg_wr_i = 1'h0, alu_arith_i = 1'h0, alu_logic_i = 1'h0;
    logic alu_rotate_i = 1'h0, alu_is_sub_i = 1'h0, alu_use_carry_i = 1'h0;
    logic alu_rot_carry_i = 1'h0, halt_exec_i = 1'h0, ext_irq_pin_i = 1'h0;
    logic watchdog_kick_i = 1'h0, watchdog_timeout_i = 1'h0;
    logic isr_exit_restore_i = 1'h0, subroutine_exit_i = 1'h0;
    logic [3:0] timer_overflow_i = 4'h0;
    wire logic stack_full_i, phase_two_pulse_i, irq_ack_o;
    wire logic [7:0] reg_rdata_o, irq_vector_o, status_o;
    int fails = 0;
    int samples_checked = 0;
    logic [7:0] v;
    logic [4:0] pw_m [5] = '{5'h01, 5'h04, 5'h02, 5'h04, 5'h01};
    logic [7:0] pw_e [5] = '{8'h1F, 8'h3F, 8'h0F, 8'h2F, 8'h1F};
    logic [7:0] al_a [5] = '{8'hFF, 8'h7F, 8'h05, 8'h80, 8'h00};
    logic [7:0] al_b [5] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01};
    logic [3:0] al_f [5] = '{4'h7, 4'hA, 4'h7, 4'h9, 4'h0};
    logic [7:0] pr_v [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [7:0] pr_l [5] = '{8'h6E, 8'h4E, 8'h0E, 8'h0E, 8'h0E};
    logic [7:0] pr_h [5] = '{8'h33, 8'h33, 8'h33, 8'h32, 8'h30};
    always #2 ref_clk_i = ~ref_clk_i;
    irqsf_core dut_u (.*);
    irqsf_seq_model model_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .ack_i(irq_ack_o), .vec_i(irq_vector_o),
        .pop_i(isr_exit_restore_i | subroutine_exit_i),
        .phase_o(phase_two_pulse_i), .full_o(stack_full_i));
    // --------------------------------
    // Shared helpers
    // --------------------------------
    task report_and_stop();
        $display("Compared %0d, mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        #1;
        v = reg_rdata_o;
        chk(n, e, v);
    endtask
    task pulse(input logic [4:0] e, input logic [3:0] t);
        @(posedge ref_clk_i);
        {subroutine_exit_i, isr_exit_restore_i, watchdog_timeout_i,
            watchdog_kick_i, halt_exec_i} <= e;
        timer_overflow_i <= t;
        @(posedge ref_clk_i);
        {subroutine_exit_i, isr_exit_restore_i, watchdog_timeout_i,
            watchdog_kick_i, halt_exec_i} <= 5'h00;
        timer_overflow_i <= 4'h0;
    endtask
    // Looks for a new take; an ack left over from before is not one
    task wait_ack(input logic [7:0] e, input logic want, input string n);
        logic pa;
        logic [7:0] pv;
        logic hit;
        // Let the edge's own updates settle before taking the baseline
        #1;
        pa = irq_ack_o;
        pv = irq_vector_o;
        hit = 1'h0;
        repeat (40)
        begin
            @(posedge ref_clk_i);
            #1;
            if (irq_ack_o === 1'h1 && (pa !== 1'h1 || irq_vector_o !== pv))
            begin
                hit = 1'h1;
                break;
            end
            pa = irq_ack_o;
            pv = irq_vector_o;
        end
        chk(n, {7'h00, want}, {7'h00, hit});
        if (hit)
            chk(n, e, irq_vector_o);
        if (want && !hit)
            report_and_stop();
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task t_regs();
        rd(8'h0A, 8'h00, "status");
        rd(8'h30, 8'h00, "unmapped");
        wr(8'h0B, 8'hFE);
        rd(8'h0B, 8'h7E, "ctrl low");
        wr(8'h1E, 8'hFF);
        rd(8'h1E, 8'h33, "ctrl high");
        wr(8'h0B, 8'h00);
        wr(8'h1E, 8'h00);
        wr(8'h0A, 8'hFF);
        rd(8'h0A, 8'h0F, "status");
    endtask
    task t_power();
        for (int i = 0; i < 5; i++)
        begin
            pulse(pw_m[i], 4'h0);
            rd(8'h0A, pw_e[i], "status");
            chk("status_o", pw_e[i], status_o);
        end
    endtask
    task t_alu();
        for (int i = 0; i < 5; i++)
        begin
            @(posedge ref_clk_i);
            alu_op_a_i <= al_a[i];
            alu_op_b_i <= al_b[i];
            alu_is_sub_i <= i >= 2;
            alu_arith_i <= 1'h1;
            @(posedge ref_clk_i);
            alu_arith_i <= 1'h0;
            rd(8'h0A, {4'h1, al_f[i]}, "alu flags");
        end
        @(posedge ref_clk_i);
        alu_logic_i <= 1'h1;
        @(posedge ref_clk_i);
        alu_logic_i <= 1'h0;
        rd(8'h0A, 8'h14, "logic zero");
        @(posedge ref_clk_i);
        alu_rotate_i <= 1'h1;
        alu_rot_carry_i <= 1'h1;
        @(posedge ref_clk_i);
        alu_rotate_i <= 1'h0;
        rd(8'h0A, 8'h15, "rotate");
        // Carry flag feeds the adder: 00 + 00 + C gives 01, no flags
        @(posedge ref_clk_i);
        alu_op_a_i <= 8'h00;
        alu_op_b_i <= 8'h00;
        alu_is_sub_i <= 1'h0;
        alu_use_carry_i <= 1'h1;
        alu_arith_i <= 1'h1;
        @(posedge ref_clk_i);
        alu_arith_i <= 1'h0;
        alu_use_carry_i <= 1'h0;
        rd(8'h0A, 8'h10, "carry in");
    endtask
    task t_prio();
        @(posedge ref_clk_i);
        ext_irq_pin_i <= 1'h1;
        pulse(5'h00, 4'hF);
        rd(8'h0B, 8'h70, "pending low");
        rd(8'h1E, 8'h03, "pending high");
        wr(8'h1E, 8'h33);
        wr(8'h0B, 8'h7F);
        for (int i = 0; i < 5; i++)
        begin
            wait_ack(pr_v[i], 1'h1, "vector");
            rd(8'h0B, pr_l[i], "ctrl low");
            rd(8'h1E, pr_h[i], "ctrl high");
            pulse(5'h08, 4'h0);
        end
    endtask
    // Hardware set and software clear land on the same edge
    task t_race();
        @(posedge ref_clk_i);
        reg_addr_i <= 8'h0B;
        reg_wdata_i <= 8'h00;
        reg_wr_i <= 1'h1;
        timer_overflow_i <= 4'h1;
        ext_irq_pin_i <= 1'h0;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'h0;
        timer_overflow_i <= 4'h0;
        rd(8'h0B, 8'h30, "race");
        wr(8'h0B, 8'h00);
        // An overflow while the enable is low must not latch
        @(posedge ref_clk_i);
        clk_en_i <= 1'h0;
        timer_overflow_i <= 4'h2;
        @(posedge ref_clk_i);
        timer_overflow_i <= 4'h0;
        clk_en_i <= 1'h1;
        rd(8'h0B, 8'h00, "frozen");
    endtask
    task t_stack();
        wr(8'h0B, 8'h05);
        pulse(5'h00, 4'h1);
        wait_ack(8'h08, 1'h1, "outer");
        wr(8'h0B, 8'h0D);
        pulse(5'h00, 4'h2);
        wait_ack(8'h0C, 1'h1, "nested");
        wr(8'h0B, 8'h0D);
        pulse(5'h00, 4'h1);
        wait_ack(8'h08, 1'h0, "full");
        rd(8'h0B, 8'h2D, "held");
        pulse(5'h08, 4'h0);
        wait_ack(8'h08, 1'h1, "popped");
        pulse(5'h10, 4'h0);
        rd(8'h0B, 8'h0C, "plain return");
        pulse(5'h08, 4'h0);
        rd(8'h0B, 8'h0D, "isr return");
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        chk("ack in reset", 8'h00, {7'h00, irq_ack_o});
        rst_b_i <= 1'h1;
        t_regs();
        t_power();
        t_alu();
        t_prio();
        t_race();
        t_stack();
        report_and_stop();
    end
endmodule
